// >>> verilog/isfsp_dev.sv
// Purpose: Device end of the two-wire port with three selectable functions.
// Assumes: Storage answers ACC_RDATA and ACC_WPROT combinationally.
// Notes: Both bus lines are oversampled by REF_CLK after two-flop synchronisers.
`timescale 1ns/1ps
module isfsp_dev
  import isfsp_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // Two-wire bus
  isfsp_if.dev BUS,
  // Address straps
  input wire logic [2:0] DEVICE_SELECT_PINS,
  // Storage access
  output logic ACC_REQ,
  output logic ACC_WE,
  output isfsp_func_t ACC_FUNC,
  output logic [15:0] ACC_ADDR,
  output logic [7:0] ACC_WDATA,
  input wire logic [7:0] ACC_RDATA,
  input wire logic ACC_WPROT,
  // Status
  output logic BUS_BUSY,
  output logic HS_MODE
);

  typedef enum logic [2:0] {ST_IDLE, ST_SEL, ST_ADDR, ST_WR, ST_RD, ST_IGN} isfsp_dst_t;

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_p;
    logic sda_p;
    logic [1:0][2:0] pin_s;
    isfsp_dst_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [1:0] alft;
    isfsp_func_t fn;
    logic [2:0][15:0] ptr;
    logic inc_pend;
    logic sda_oe;
    logic busy;
    logic hs;
    logic req;
    logic we;
    logic [7:0] wd;
    logic [15:0] addr;
  } isfsp_dstate_t;

  isfsp_dstate_t r_ff;
  isfsp_dstate_t nxt_r;

  function automatic logic [15:0] span_mask(input isfsp_func_t f);
    case (f)
      FN_MEM: span_mask = MEM_SPAN_MASK;
      FN_RTC: span_mask = RTC_SPAN_MASK;
      default: span_mask = CTL_SPAN_MASK;
    endcase
  endfunction

  function automatic logic nib_known(input logic [3:0] n);
    nib_known = (n == NIB_MEM) || (n == NIB_RTC) || (n == NIB_CTL);
  endfunction

  function automatic isfsp_func_t nib_func(input logic [3:0] n);
    if (n == NIB_MEM) begin
      nib_func = FN_MEM;
    end else if (n == NIB_RTC) begin
      nib_func = FN_RTC;
    end else begin
      nib_func = FN_CTL;
    end
  endfunction

  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.scl_s = {r_ff.scl_s[0], BUS.scl_line};
    nxt_r.sda_s = {r_ff.sda_s[0], BUS.sda_line};
    nxt_r.scl_p = r_ff.scl_s[1];
    nxt_r.sda_p = r_ff.sda_s[1];
    nxt_r.pin_s = {r_ff.pin_s[0], DEVICE_SELECT_PINS};
    nxt_r.req = 1'b0;
    scl = r_ff.scl_s[1];
    sda = r_ff.sda_s[1];
    rise = scl & ~r_ff.scl_p;
    fall = ~scl & r_ff.scl_p;
    start = scl & r_ff.scl_p & r_ff.sda_p & ~sda;
    stop = scl & r_ff.scl_p & ~r_ff.sda_p & sda;
    // Read data is taken in the cycle the request stands.
    if (r_ff.req && !r_ff.we) begin
      nxt_r.sh = ACC_RDATA;
    end
    // Post-increment runs one cycle after a write so the write sees the old address.
    if (r_ff.inc_pend) begin
      nxt_r.inc_pend = 1'b0;
      nxt_r.ptr[r_ff.fn] = (r_ff.ptr[r_ff.fn] + 16'h0001) & span_mask(r_ff.fn);
      if (r_ff.st == ST_RD) begin
        nxt_r.req = 1'b1;
        nxt_r.we = 1'b0;
      end
    end
    if (stop) begin
      nxt_r.st = ST_IDLE;
      nxt_r.busy = 1'b0;
      nxt_r.hs = 1'b0;
      nxt_r.sda_oe = 1'b0;
    end else if (start) begin
      nxt_r.st = ST_SEL;
      nxt_r.cnt = 4'h0;
      nxt_r.busy = 1'b1;
      nxt_r.sda_oe = 1'b0;
    end else if (r_ff.st != ST_IDLE && r_ff.st != ST_IGN) begin
      if (rise) begin
        if (r_ff.cnt < BIT_DONE) begin
          nxt_r.cnt = r_ff.cnt + 4'h1;
          if (r_ff.st != ST_RD) begin
            nxt_r.sh = {r_ff.sh[6:0], sda};
          end
        end else if (r_ff.cnt == BIT_ACK && r_ff.st == ST_RD && sda) begin
          nxt_r.st = ST_IGN;
        end
      end else if (fall) begin
        if (r_ff.cnt == BIT_DONE) begin
          nxt_r.cnt = BIT_ACK;
          case (r_ff.st)
            ST_SEL: begin
              if (r_ff.sh[7:3] == HS_CODE_TOP) begin
                nxt_r.hs = 1'b1;
                nxt_r.st = ST_IGN;
                nxt_r.sda_oe = 1'b0;
              end else if (nib_known(r_ff.sh[7:4]) && r_ff.sh[3:1] == r_ff.pin_s[1]) begin
                nxt_r.sda_oe = 1'b1;
                nxt_r.fn = nib_func(r_ff.sh[7:4]);
                if (r_ff.sh[0]) begin
                  nxt_r.st = ST_RD;
                  nxt_r.req = 1'b1;
                  nxt_r.we = 1'b0;
                end else begin
                  nxt_r.st = ST_ADDR;
                  nxt_r.alft = (nib_func(r_ff.sh[7:4]) == FN_MEM) ? MEM_ADDR_BYTES
                                                                  : REG_ADDR_BYTES;
                end
              end else begin
                nxt_r.sda_oe = 1'b0;
                nxt_r.st = ST_IGN;
              end
            end
            ST_ADDR: begin
              nxt_r.sda_oe = 1'b1;
              if (r_ff.alft == MEM_ADDR_BYTES) begin
                nxt_r.ptr[r_ff.fn][15:8] = r_ff.sh;
              end else begin
                nxt_r.ptr[r_ff.fn] = {r_ff.ptr[r_ff.fn][15:8], r_ff.sh} &
                                     span_mask(r_ff.fn);
              end
              nxt_r.alft = r_ff.alft - 2'h1;
              if (r_ff.alft == REG_ADDR_BYTES) begin
                nxt_r.st = ST_WR;
              end
            end
            ST_WR: begin
              if (ACC_WPROT) begin
                nxt_r.sda_oe = 1'b0;
                nxt_r.st = ST_IGN;
              end else begin
                nxt_r.sda_oe = 1'b1;
                nxt_r.req = 1'b1;
                nxt_r.we = 1'b1;
                nxt_r.wd = r_ff.sh;
                nxt_r.inc_pend = 1'b1;
              end
            end
            ST_RD: begin
              nxt_r.sda_oe = 1'b0;
              nxt_r.inc_pend = 1'b1;
            end
            default: begin
              nxt_r.sda_oe = 1'b0;
            end
          endcase
        end else if (r_ff.cnt == BIT_ACK) begin
          nxt_r.cnt = 4'h0;
          nxt_r.sda_oe = (r_ff.st == ST_RD) & ~r_ff.sh[7];
        end else if (r_ff.st == ST_RD && r_ff.cnt != 4'h0) begin
          nxt_r.sh = {r_ff.sh[6:0], 1'b0};
          nxt_r.sda_oe = ~r_ff.sh[6];
        end
      end
    end
    nxt_r.addr = nxt_r.ptr[nxt_r.fn];
  end

  // Syncs reset to the idle-high line level so no false start shows after reset.
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r_ff <= '0;
      r_ff.scl_s <= SYNC_IDLE;
      r_ff.sda_s <= SYNC_IDLE;
      r_ff.scl_p <= 1'b1;
      r_ff.sda_p <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign BUS.dev_sda_o = 1'b0;
  assign BUS.dev_sda_oe = r_ff.sda_oe;
  assign ACC_REQ = r_ff.req;
  assign ACC_WE = r_ff.we;
  assign ACC_FUNC = r_ff.fn;
  assign ACC_ADDR = r_ff.addr;
  assign ACC_WDATA = r_ff.wd;
  assign BUS_BUSY = r_ff.busy;
  assign HS_MODE = r_ff.hs;

endmodule // isfsp_dev

// >>> verilog/isfsp_pkg.sv
// Purpose: Shared constants and types for the two-wire function-select port.
// Assumes: Both ends run on a 200 MHz reference clock.
// Notes: Bus line levels are resolved in the interface, never in the ends.
package isfsp_pkg;
  // Clock and bus timing.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SCL_PERIOD_NS = 2500;
  localparam logic [15:0] SCL_QTR_CYCLES = 16'((SCL_PERIOD_NS * 1000 / 4) / CLK_PERIOD_PS);
  // Reset value of a synchroniser on an idle-high line.
  localparam logic [1:0] SYNC_IDLE = 2'h3;
  // Bit counter landmarks inside one byte frame.
  localparam logic [3:0] BIT_DONE = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;
  // Select byte decode.
  localparam logic [3:0] NIB_MEM = 4'hA;
  localparam logic [3:0] NIB_RTC = 4'hD;
  localparam logic [3:0] NIB_CTL = 4'h3;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  // Address phase lengths and pointer spans.
  localparam logic [1:0] MEM_ADDR_BYTES = 2'h2;
  localparam logic [1:0] REG_ADDR_BYTES = 2'h1;
  localparam logic [15:0] MEM_SPAN_MASK = 16'hFFFF;
  localparam logic [15:0] RTC_SPAN_MASK = 16'h000F;
  localparam logic [15:0] CTL_SPAN_MASK = 16'h00FF;

  typedef enum logic [1:0] {FN_MEM, FN_RTC, FN_CTL} isfsp_func_t;
  typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_WRITE, CMD_READ} isfsp_cmd_t;
endpackage

// >>> verilog/isfsp_if.sv
// Purpose: Two-wire bus joining the master end and the device end.
// Assumes: Both lines are open drain with a pull-up.
// Notes: A line is low when any driver enables a low output.
`timescale 1ns/1ps
interface isfsp_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl_line;
  logic sda_line;

  assign scl_line = ~(host_scl_oe & ~host_scl_o);
  assign sda_line = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport dev (input scl_line, input sda_line, output dev_sda_o, output dev_sda_oe);
  modport host (input scl_line, input sda_line, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface

// >>> verilog/isfsp_host.sv
// Purpose: Master end of the two-wire port, one bus operation per command.
// Assumes: No clock stretching by the device and a single master.
// Notes: SCL comes from a divider of REF_CLK in four quarter steps per bit.
`timescale 1ns/1ps
module isfsp_host
  import isfsp_pkg::*;
#(
  parameter logic [15:0] QTR_CYCLES = SCL_QTR_CYCLES
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // Two-wire bus
  isfsp_if.host BUS,
  // Command
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire isfsp_cmd_t CMD_KIND,
  input wire logic [7:0] CMD_DATA,
  input wire logic CMD_ACK,
  // Response
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic RSP_ACK
);

  typedef enum logic {H_IDLE, H_RUN} isfsp_hst_t;

  typedef struct packed {
    logic [1:0] sda_s;
    isfsp_hst_t st;
    isfsp_cmd_t kind;
    logic [15:0] qcnt;
    logic [1:0] step;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic ackv;
    logic scl_low;
    logic sda_low;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_ack;
  } isfsp_hstate_t;

  isfsp_hstate_t r_ff;
  isfsp_hstate_t nxt_r;
  logic last;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.sda_s = {r_ff.sda_s[0], BUS.sda_line};
    nxt_r.rsp_valid = 1'b0;
    last = 1'b0;
    if (r_ff.st == H_IDLE) begin
      if (CMD_VALID) begin
        nxt_r.st = H_RUN;
        nxt_r.kind = CMD_KIND;
        nxt_r.sh = CMD_DATA;
        nxt_r.ackv = CMD_ACK;
        nxt_r.step = 2'h0;
        nxt_r.bitn = 4'h0;
        nxt_r.qcnt = QTR_CYCLES - 16'h0001;
      end
    end else if (r_ff.qcnt != 16'h0000) begin
      nxt_r.qcnt = r_ff.qcnt - 16'h0001;
    end else begin
      nxt_r.qcnt = QTR_CYCLES - 16'h0001;
      nxt_r.step = r_ff.step + 2'h1;
      case (r_ff.kind)
        CMD_START: begin
          // A start from a held-low clock is a repeated start.
          case (r_ff.step)
            2'h0: nxt_r.sda_low = 1'b0;
            2'h1: nxt_r.scl_low = 1'b0;
            2'h2: nxt_r.sda_low = 1'b1;
            default: begin
              nxt_r.scl_low = 1'b1;
              last = 1'b1;
            end
          endcase
        end
        CMD_STOP: begin
          case (r_ff.step)
            2'h0: nxt_r.sda_low = 1'b1;
            2'h1: nxt_r.scl_low = 1'b0;
            2'h2: nxt_r.sda_low = 1'b0;
            default: last = 1'b1;
          endcase
        end
        default: begin
          case (r_ff.step)
            2'h0: begin
              if (r_ff.bitn == BIT_DONE) begin
                nxt_r.sda_low = (r_ff.kind == CMD_READ) & r_ff.ackv;
              end else begin
                nxt_r.sda_low = (r_ff.kind == CMD_WRITE) & ~r_ff.sh[7];
              end
            end
            2'h1: nxt_r.scl_low = 1'b0;
            2'h2: begin
              if (r_ff.bitn == BIT_DONE) begin
                nxt_r.rsp_ack = ~r_ff.sda_s[1];
              end else begin
                nxt_r.sh = {r_ff.sh[6:0], r_ff.sda_s[1]};
              end
            end
            default: begin
              nxt_r.scl_low = 1'b1;
              nxt_r.bitn = r_ff.bitn + 4'h1;
              last = (r_ff.bitn == BIT_DONE);
            end
          endcase
        end
      endcase
      if (last) begin
        nxt_r.st = H_IDLE;
        nxt_r.rsp_valid = 1'b1;
        nxt_r.rsp_data = r_ff.sh;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r_ff <= '0;
      r_ff.sda_s <= SYNC_IDLE;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign CMD_READY = (r_ff.st == H_IDLE);
  assign BUS.host_scl_o = 1'b0;
  assign BUS.host_scl_oe = r_ff.scl_low;
  assign BUS.host_sda_o = 1'b0;
  assign BUS.host_sda_oe = r_ff.sda_low;
  assign RSP_VALID = r_ff.rsp_valid;
  assign RSP_DATA = r_ff.rsp_data;
  assign RSP_ACK = r_ff.rsp_ack;

endmodule // isfsp_host

// >>> dv/isfsp_sva.sv
// Purpose: Line-level checks between the master end and the device end.
// Assumes: One master and no clock stretching; lines are sampled raw by REF_CLK.
// Notes: A small byte tracker follows the framing so checks can name the ack slot.
`timescale 1ns/1ps
module isfsp_sva
  import isfsp_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // Straps
  input wire logic [2:0] DEVICE_SELECT_PINS,
  // Bus lines
  input wire logic scl_line,
  input wire logic sda_line,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  // Status
  input wire logic hs_mode
);
  logic scl_q_ff;
  logic sda_q_ff;
  logic [3:0] bit_ff;
  logic [1:0] byte_ff;
  logic [7:0] sel_ff;
  logic mute_ff;
  logic rise;
  logic ack_slot;
  logic sel_ok;

  // Start and stop both reopen framing, so a stray stop cannot leave the tracker muted.
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      bit_ff <= 4'h0;
      byte_ff <= 2'h0;
      sel_ff <= 8'h00;
      mute_ff <= 1'b0;
    end else begin
      scl_q_ff <= scl_line;
      sda_q_ff <= sda_line;
      if (scl_line && scl_q_ff && (sda_line != sda_q_ff)) begin
        bit_ff <= 4'h0;
        byte_ff <= 2'h0;
        mute_ff <= 1'b0;
      end else if (rise && bit_ff == BIT_DONE) begin
        bit_ff <= 4'h0;
        byte_ff <= (byte_ff == 2'h3) ? byte_ff : byte_ff + 2'h1;
        mute_ff <= mute_ff | sda_line;
      end else if (rise) begin
        bit_ff <= bit_ff + 4'h1;
        sel_ff <= (byte_ff == 2'h0) ? {sel_ff[6:0], sda_line} : sel_ff;
      end
    end
  end

  assign rise = scl_line && !scl_q_ff;
  assign ack_slot = rise && (bit_ff == BIT_DONE);
  assign sel_ok = (sel_ff[7:4] == NIB_MEM || sel_ff[7:4] == NIB_RTC || sel_ff[7:4] == NIB_CTL)
                  && (sel_ff[3:1] == DEVICE_SELECT_PINS);

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  property p_quiet_high;
    scl_line && $past(scl_line) |-> $stable(dev_sda_oe);
  endproperty
  a_quiet_high: assert property (p_quiet_high)
    else $error("device moved SDA while SCL high");
  property p_no_contend;
    scl_line && dev_sda_oe |-> !host_sda_oe;
  endproperty
  a_no_contend: assert property (p_no_contend)
    else $error("both ends drive SDA");
  property p_ack_only;
    rise && dev_sda_oe && bit_ff != BIT_DONE |-> byte_ff != 2'h0 && sel_ff[0];
  endproperty
  a_ack_only: assert property (p_ack_only)
    else $error("device drove a data bit in a write");
  property p_sel_ack;
    ack_slot && byte_ff == 2'h0 && sel_ok |-> dev_sda_oe;
  endproperty
  a_sel_ack: assert property (p_sel_ack)
    else $error("matching select byte not acknowledged");
  property p_sel_nak;
    ack_slot && byte_ff == 2'h0 && !sel_ok |-> !dev_sda_oe;
  endproperty
  a_sel_nak: assert property (p_sel_nak)
    else $error("foreign select byte acknowledged");
  // A plain nack would also pass for an unknown nibble, so the mode flag is checked too.
  property p_hs_code;
    ack_slot && byte_ff == 2'h0 && sel_ff[7:3] == HS_CODE_TOP |-> !dev_sda_oe && hs_mode;
  endproperty
  a_hs_code: assert property (p_hs_code)
    else $error("master code acknowledged or high speed not entered");
  property p_rd_release;
    ack_slot && byte_ff != 2'h0 && sel_ff[0] |-> !dev_sda_oe;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("device held SDA in master ack slot");
  property p_mute;
    mute_ff |-> !dev_sda_oe;
  endproperty
  a_mute: assert property (p_mute)
    else $error("device drove SDA after a refusal");

  c_sel_ack: cover property (ack_slot && byte_ff == 2'h0 && dev_sda_oe);
  c_read_nak: cover property (ack_slot && byte_ff != 2'h0 && sel_ff[0] && sda_line);
  c_hs: cover property (ack_slot && byte_ff == 2'h0 && sel_ff[7:3] == HS_CODE_TOP);
endmodule // isfsp_sva

// >>> dv/tb_i2c_slave_function_select_port.sv
// Purpose: Self-checking bench joining the master end and the device end.
// Assumes: Storage and write protection live here; host quarter step is 8 clocks.
// Notes: Expected bytes come from a bench mirror, never from the storage port.
`timescale 1ns/1ps
module tb_i2c_slave_function_select_port;
  import isfsp_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] pins = 3'h0;
  logic cmd_valid = 1'b0;
  isfsp_cmd_t cmd_kind = CMD_STOP;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ack = 1'b0;
  logic wp_on = 1'b0;
  logic hs_exp = 1'b0;
  logic cmd_ready, rsp_valid, rsp_ack, acc_req, acc_we, bus_busy, hs_mode;
  logic [7:0] rsp_data, acc_wdata;
  logic [15:0] acc_addr;
  isfsp_func_t acc_func;
  bit [7:0] store [0:262143];
  bit [7:0] mirror [0:262143];
  logic [15:0] ptr [0:2];
  logic [3:0] nibs [0:2] = '{NIB_MEM, NIB_RTC, NIB_CTL};
  int failures = 0;
  int compares = 0;
  int seed = 32'h543F611F;
  isfsp_if bus ();

  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (acc_req && acc_we) begin
      store[{acc_func, acc_addr}] <= acc_wdata;
    end
  end

  isfsp_dev isfsp_dev_i (.REF_CLK(ref_clk), .RESET_N(reset_n), .BUS(bus.dev),
    .DEVICE_SELECT_PINS(pins), .ACC_REQ(acc_req), .ACC_WE(acc_we), .ACC_FUNC(acc_func),
    .ACC_ADDR(acc_addr), .ACC_WDATA(acc_wdata), .ACC_RDATA(store[{acc_func, acc_addr}]),
    .ACC_WPROT(wp_on && acc_func == FN_MEM && acc_addr[15]), .BUS_BUSY(bus_busy),
    .HS_MODE(hs_mode));
  isfsp_host #(.QTR_CYCLES(16'h0008)) isfsp_host_i (.REF_CLK(ref_clk), .RESET_N(reset_n),
    .BUS(bus.host), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_KIND(cmd_kind),
    .CMD_DATA(cmd_data), .CMD_ACK(cmd_ack), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
    .RSP_ACK(rsp_ack));
  isfsp_sva isfsp_sva_i (.REF_CLK(ref_clk), .RESET_N(reset_n), .DEVICE_SELECT_PINS(pins),
    .scl_line(bus.scl_line), .sda_line(bus.sda_line), .host_sda_oe(bus.host_sda_oe),
    .dev_sda_oe(bus.dev_sda_oe), .hs_mode(hs_mode));

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  function automatic logic [15:0] span(input int f);
    return (f == 0) ? MEM_SPAN_MASK : ((f == 1) ? RTC_SPAN_MASK : CTL_SPAN_MASK);
  endfunction

  // Valid is raised once the host is idle or after 50 clocks, so the next edge takes it when the host is idle.
  task automatic op(input isfsp_cmd_t k, input logic [7:0] d, input logic a);
    for (int n = 0; n < 50 && cmd_ready !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_data = d;
    cmd_ack = a;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    for (int n = 0; n < 400 && rsp_valid !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("rsp_valid", 16'(rsp_valid), 16'h0001);
    if (k == CMD_START || k == CMD_STOP) begin
      repeat (4) @(posedge ref_clk);
      #1;
    end
  endtask

  task automatic wbyte(input logic [7:0] d, input logic ea);
    op(CMD_WRITE, d, 1'b0);
    chk("ack", 16'(rsp_ack), 16'(ea));
  endtask

  task automatic xfer(input int f, input bit setp, input logic [15:0] a, input int nw,
                      input int nr);
    logic [7:0] d;
    op(CMD_START, 8'h00, 1'b0);
    chk("busy", 16'(bus_busy), 16'h0001);
    chk("hs", 16'(hs_mode), 16'(hs_exp));
    if (setp || nw > 0) begin
      wbyte({nibs[f], pins, 1'b0}, 1'b1);
      if (setp) begin
        if (f == 0) wbyte(a[15:8], 1'b1);
        wbyte(a[7:0], 1'b1);
        ptr[f] = a & span(f);
      end
      for (int i = 0; i < nw; i++) begin
        d = 8'($random(seed));
        if (wp_on && f == 0 && ptr[f][15]) begin
          wbyte(d, 1'b0);
          break;
        end
        wbyte(d, 1'b1);
        mirror[{f[1:0], ptr[f]}] = d;
        ptr[f] = (ptr[f] + 16'h0001) & span(f);
      end
    end
    if (nr > 0) begin
      if (setp || nw > 0) op(CMD_START, 8'h00, 1'b0);
      wbyte({nibs[f], pins, 1'b1}, 1'b1);
      for (int i = 0; i < nr; i++) begin
        op(CMD_READ, 8'h00, i < nr - 1);
        chk("rdata", 16'(rsp_data), 16'(mirror[{f[1:0], ptr[f]}]));
        ptr[f] = (ptr[f] + 16'h0001) & span(f);
      end
    end
    op(CMD_STOP, 8'h00, 1'b0);
    hs_exp = 1'b0;
    chk("busy", 16'(bus_busy), 16'h0000);
    chk("hs", 16'(hs_mode), 16'h0000);
  endtask

  // After a refused select the device must stay silent for the rest of the transfer.
  task automatic badsel(input logic [7:0] s);
    op(CMD_START, 8'h00, 1'b0);
    wbyte(s, 1'b0);
    wbyte({NIB_MEM, pins, 1'b0}, 1'b0);
    op(CMD_STOP, 8'h00, 1'b0);
  endtask

  initial begin
    int f;
    int n;
    logic [15:0] a;
    repeat (20) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    pins = 3'($random(seed));
    repeat (4) @(posedge ref_clk);
    #1;
    for (int k = 0; k < 9; k++) begin
      f = k % 3;
      a = 16'($random(seed));
      n = 1 + ({$random(seed)} % 4);
      xfer(f, 1'b1, a, n, 0);
      xfer(f, 1'b1, a, 0, n);
    end
    xfer(0, 1'b1, 16'hFFFE, 3, 0);
    xfer(0, 1'b1, 16'hFFFE, 0, 3);
    xfer(0, 1'b0, 16'h0000, 0, 2);
    xfer(1, 1'b1, 16'h000E, 3, 0);
    xfer(1, 1'b1, 16'h000E, 0, 3);
    xfer(2, 1'b1, 16'h00FF, 2, 0);
    xfer(0, 1'b0, 16'h0000, 0, 1);
    badsel(8'h50);
    badsel({NIB_MEM, ~pins, 1'b0});
    badsel({NIB_RTC, pins ^ 3'h4, 1'b1});
    pins = pins + 3'h1;
    repeat (8) @(posedge ref_clk);
    #1;
    wp_on = 1'b1;
    xfer(0, 1'b1, 16'h8001, 2, 0);
    wp_on = 1'b0;
    xfer(0, 1'b1, 16'h8001, 0, 1);
    op(CMD_START, 8'h00, 1'b0);
    wbyte(8'h0B, 1'b0);
    hs_exp = 1'b1;
    chk("hs", 16'(hs_mode), 16'h0001);
    xfer(0, 1'b1, 16'h1234, 2, 2);
    wrap_up();
  end

  initial begin
    repeat (90000) @(posedge ref_clk);
    failures++;
    wrap_up();
  end
endmodule // tb_i2c_slave_function_select_port
